// >>> inc/tcw_consts.svh
// constants of the timer/compare/waveform unit: offsets, fields, resets
// assumes an 8-bit APB address window and 32-bit data
`ifndef TCW_CONSTS_SVH
`define TCW_CONSTS_SVH

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define TCW_OFF_CTRL      8'h00
`define TCW_OFF_COUNT     8'h04
`define TCW_OFF_COMPARE   8'h08
`define TCW_OFF_STATUS    8'h0C
`define TCW_OFF_PINCFG    8'h10

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define TCW_BIT_FORCE     7
`define TCW_BIT_WAVE_LO   6
`define TCW_BIT_ACT_HI    5
`define TCW_BIT_ACT_LO    4
`define TCW_BIT_WAVE_HI   3
`define TCW_BIT_PSC_HI    2
`define TCW_BIT_OVF       0
`define TCW_BIT_CMF       1
`define TCW_BIT_DIR       0
`define TCW_BIT_ASYNC     1

// ------------------------------------------------------------------
// reset values and counter limits
// ------------------------------------------------------------------
`define TCW_RST_CTRL      7'h00
`define TCW_RST_COUNT     8'h00
`define TCW_RST_COMPARE   8'h00
`define TCW_RST_PINCFG    2'h0
`define TCW_MAX           8'hFF
`define TCW_BOTTOM        8'h00

`endif

// >>> inc/tcw_pkg.sv
// types of the timer/compare/waveform unit
// assumes tcw_consts.svh is on the include path
package tcw_pkg;

   typedef enum logic [1:0] {
      TCW_NORMAL,
      TCW_PHASE_PWM,
      TCW_CLEAR_ON_MATCH,
      TCW_FAST_PWM
   } tcw_mode_e;

   typedef struct packed {
      logic [6:0]  ctrl;
      logic [7:0]  cnt;
      logic [7:0]  ocr;
      logic [7:0]  ocr_buf;
      logic        down;
      logic        block;
      logic [9:0]  psc;
      logic        ovf;
      logic        cmf;
      logic        oc;
      logic [1:0]  cfg;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        pin;
      logic        pin_oe;
   } tcw_state_s;

endpackage

// >>> design/tcw_timer.sv
// 8-bit timer/counter with compare unit and waveform generator, APB slave
// assumes APB master keeps the request stable until pready; one clock;
// tosc_tick_i is a one-cycle pulse synchronous to clk_i
//
// Functional notes
// - force strobe acts only in normal or clear-on-match modes
// - force strobe applies the selected output action to the pin at once
// - forced compare sets no flag and never clears the counter
// - force strobe reads back as zero
// - wave mode bits 6 (low) and 3 (high) pick one of four modes
// - top is 0xFF, except clear-on-match where top is compare value
// - compare write immediate or buffered to top; overflow at MAX/BOTTOM
// - nonzero action overrides port data; driver follows direction bit
// - non-PWM actions: disconnect, toggle, clear, set on match
// - fast PWM: clear or set on match, opposite at top
// - phase PWM: action on upward match, reverse on downward match
// - in PWM modes, compare equal to top with high action bit: match ignored, top acts
// - prescale select picks source divided by 1,8,32,64,128,256,1024
// - prescale select zero stops the counter
// - counter register reads and writes the counter directly
// - counter write suppresses compare match on next timer tick
// - compare value checked continuously; match sets flag, drives output
// - tick enables io clock; async mode uses oscillator ticks instead
// - fast PWM counts to MAX then clears to BOTTOM next tick
// - phase PWM counts up, holds MAX one tick, counts down
//
// The APB register port and the register offsets are this design's own decisions.
`include "tcw_consts.svh"

module tcw_timer (
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        tosc_tick_i,
   input  wire logic        port_out_i,
   output logic             compare_out_pin_o,
   output logic             compare_out_oe_o,
   output logic             overflow_flag_o,
   output logic             compare_match_flag_o
);

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic [9:0] psc_mask(input logic [2:0] sel);
      case (sel)
         3'h2:    psc_mask = 10'h007;
         3'h3:    psc_mask = 10'h01F;
         3'h4:    psc_mask = 10'h03F;
         3'h5:    psc_mask = 10'h07F;
         3'h6:    psc_mask = 10'h0FF;
         3'h7:    psc_mask = 10'h3FF;
         default: psc_mask = 10'h000;
      endcase
   endfunction

   tcw_pkg::tcw_state_s s_q;
   tcw_pkg::tcw_state_s s_d;

   logic                setup;
   logic                access;
   logic                wr;
   logic                wr_ctrl;
   logic                wr_cnt;
   logic                wr_cmp;
   logic                wr_stat;
   logic                hit;
   logic                src;
   logic                tick;
   logic                match;
   logic                pwm;
   logic                force_cmp;
   logic                at_top;
   logic                hold_top;
   logic                wr_pwm;
   logic [1:0]          wr_act;
   logic [2:0]          psc_sel;
   logic [1:0]          act;
   logic [7:0]          top;
   tcw_pkg::tcw_mode_e  mode;

   // ------------------------------------------------------------------
   // decode
   // ------------------------------------------------------------------
   assign setup   = psel_i & ~penable_i;
   assign access  = psel_i & penable_i & s_q.pready;
   assign wr      = access & pwrite_i & ~s_q.pslverr;
   assign wr_ctrl = wr & (paddr_i == `TCW_OFF_CTRL);
   assign wr_cnt  = wr & (paddr_i == `TCW_OFF_COUNT);
   assign wr_cmp  = wr & (paddr_i == `TCW_OFF_COMPARE);
   assign wr_stat = wr & (paddr_i == `TCW_OFF_STATUS);
   assign hit     = (paddr_i == `TCW_OFF_CTRL) | (paddr_i == `TCW_OFF_COUNT)
                  | (paddr_i == `TCW_OFF_COMPARE)
                  | (paddr_i == `TCW_OFF_STATUS)
                  | (paddr_i == `TCW_OFF_PINCFG);

   assign mode    = tcw_pkg::tcw_mode_e'({s_q.ctrl[`TCW_BIT_WAVE_HI],
                                          s_q.ctrl[`TCW_BIT_WAVE_LO]});
   assign pwm     = (mode == tcw_pkg::TCW_PHASE_PWM)
                  | (mode == tcw_pkg::TCW_FAST_PWM);
   assign act     = s_q.ctrl[`TCW_BIT_ACT_HI:`TCW_BIT_ACT_LO];
   assign psc_sel = s_q.ctrl[`TCW_BIT_PSC_HI:0];
   assign top     = (mode == tcw_pkg::TCW_CLEAR_ON_MATCH) ? s_q.ocr
                  : `TCW_MAX;

   // ------------------------------------------------------------------
   // timer tick: oscillator pulses replace the io clock in async mode
   // ------------------------------------------------------------------
   assign src  = s_q.cfg[`TCW_BIT_ASYNC] ? tosc_tick_i : 1'b1;
   assign tick = src & (psc_sel != 3'h0)
               & ((s_q.psc & psc_mask(psc_sel)) == psc_mask(psc_sel));

   assign match     = (s_q.cnt == s_q.ocr);
   assign at_top    = (s_q.cnt == `TCW_MAX);
   assign hold_top  = pwm & (s_q.ocr == `TCW_MAX) & act[1];
   // strobe judged by the mode and action written along with it
   assign wr_pwm    = pwdata_i[`TCW_BIT_WAVE_LO];
   assign wr_act    = pwdata_i[`TCW_BIT_ACT_HI:`TCW_BIT_ACT_LO];
   assign force_cmp = wr_ctrl & pwdata_i[`TCW_BIT_FORCE] & ~wr_pwm;

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      s_d = s_q;

      // stale direction would make phase mode start downwards
      if (mode != tcw_pkg::TCW_PHASE_PWM) begin
         s_d.down = 1'b0;
      end
      // write one to clear, ahead of the events so that a set wins
      if (wr_stat) begin
         s_d.ovf = s_q.ovf & ~pwdata_i[`TCW_BIT_OVF];
         s_d.cmf = s_q.cmf & ~pwdata_i[`TCW_BIT_CMF];
      end

      // prescaler runs on every source pulse while a clock is selected
      if (src && psc_sel != 3'h0) begin
         s_d.psc = s_q.psc + 10'h001;
      end

      if (tick) begin
         s_d.block = 1'b0;
         if (match && !s_q.block) begin
            s_d.cmf = 1'b1;
         end
         case (mode)
            tcw_pkg::TCW_PHASE_PWM: begin
               if (!s_q.down) begin
                  if (at_top) begin
                     s_d.down = 1'b1;
                     s_d.cnt  = `TCW_MAX - 8'h01;
                  end else begin
                     s_d.cnt = s_q.cnt + 8'h01;
                  end
               end else if (s_q.cnt == `TCW_BOTTOM) begin
                  s_d.down = 1'b0;
                  s_d.cnt  = s_q.cnt + 8'h01;
                  s_d.ovf  = 1'b1;
               end else begin
                  s_d.cnt = s_q.cnt - 8'h01;
               end
               if (s_q.cnt == `TCW_BOTTOM && !s_q.down) begin
                  s_d.ovf = 1'b1;
               end
               // match actions, held back when compare sits at top
               if (match && !s_q.block && !hold_top) begin
                  if (act == 2'h2) begin
                     s_d.oc = s_q.down;
                  end else if (act == 2'h3) begin
                     s_d.oc = ~s_q.down;
                  end
               end
               if (hold_top && at_top) begin
                  s_d.oc = (act == 2'h2);
               end
            end
            tcw_pkg::TCW_FAST_PWM: begin
               s_d.cnt = s_q.cnt + 8'h01;
               if (match && !s_q.block && !hold_top) begin
                  if (act == 2'h2) begin
                     s_d.oc = 1'b0;
                  end else if (act == 2'h3) begin
                     s_d.oc = 1'b1;
                  end
               end
               if (at_top) begin
                  s_d.ovf = 1'b1;
                  if (act == 2'h2) begin
                     s_d.oc = 1'b1;
                  end else if (act == 2'h3) begin
                     s_d.oc = 1'b0;
                  end
               end
            end
            default: begin
               // normal and clear-on-match share the non-PWM actions
               if (mode == tcw_pkg::TCW_CLEAR_ON_MATCH && match
                   && !s_q.block) begin
                  s_d.cnt = `TCW_BOTTOM;
               end else begin
                  s_d.cnt = s_q.cnt + 8'h01;
               end
               if (at_top) begin
                  s_d.ovf = 1'b1;
               end
               if (match && !s_q.block) begin
                  case (act)
                     2'h1:    s_d.oc = ~s_q.oc;
                     2'h2:    s_d.oc = 1'b0;
                     2'h3:    s_d.oc = 1'b1;
                     default: s_d.oc = s_q.oc;
                  endcase
               end
            end
         endcase
         // buffered compare value lands when the count passes top
         if (pwm && at_top) begin
            s_d.ocr = s_q.ocr_buf;
         end
      end

      // forced compare: output only, no flag and no counter clear
      if (force_cmp) begin
         case (wr_act)
            2'h1:    s_d.oc = ~s_q.oc;
            2'h2:    s_d.oc = 1'b0;
            2'h3:    s_d.oc = 1'b1;
            default: ;
         endcase
      end

      // ------------------------------------------------------------------
      // register writes; a bus write to the counter beats the tick
      // ------------------------------------------------------------------
      if (wr_ctrl) begin
         s_d.ctrl = pwdata_i[6:0];
      end
      if (wr_cnt) begin
         s_d.cnt   = pwdata_i[7:0];
         s_d.block = 1'b1;
      end
      if (wr_cmp) begin
         s_d.ocr_buf = pwdata_i[7:0];
         if (!pwm) begin
            s_d.ocr = pwdata_i[7:0];
         end
      end
      if (wr & (paddr_i == `TCW_OFF_PINCFG)) begin
         s_d.cfg = pwdata_i[1:0];
      end

      // ------------------------------------------------------------------
      // APB answer: ready one cycle after setup, data sampled at setup
      // ------------------------------------------------------------------
      s_d.pready = setup;
      if (setup) begin
         s_d.pslverr = ~hit;
         case (paddr_i)
            `TCW_OFF_CTRL:    s_d.prdata = {25'h0, s_q.ctrl};
            `TCW_OFF_COUNT:   s_d.prdata = {24'h0, s_q.cnt};
            `TCW_OFF_COMPARE: s_d.prdata = {24'h0, s_q.ocr_buf};
            `TCW_OFF_STATUS:  s_d.prdata = {30'h0, s_q.cmf, s_q.ovf};
            `TCW_OFF_PINCFG:  s_d.prdata = {30'h0, s_q.cfg};
            default:          s_d.prdata = 32'h0;
         endcase
      end

      // pin override while any action bit is set
      s_d.pin    = (s_d.ctrl[`TCW_BIT_ACT_HI:`TCW_BIT_ACT_LO] != 2'h0)
                 ? s_d.oc : port_out_i;
      s_d.pin_oe = s_d.cfg[`TCW_BIT_DIR];
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_q         <= '0;
         s_q.ctrl    <= `TCW_RST_CTRL;
         s_q.cnt     <= `TCW_RST_COUNT;
         s_q.ocr     <= `TCW_RST_COMPARE;
         s_q.ocr_buf <= `TCW_RST_COMPARE;
         s_q.cfg     <= `TCW_RST_PINCFG;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata_o             = s_q.prdata;
   assign pready_o             = s_q.pready;
   assign pslverr_o            = s_q.pslverr;
   assign compare_out_pin_o    = s_q.pin;
   assign compare_out_oe_o     = s_q.pin_oe;
   assign overflow_flag_o      = s_q.ovf;
   assign compare_match_flag_o = s_q.cmf;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   sequence force_toggle_s;
      force_cmp && wr_act == 2'h1 && !(tick && match && !s_q.block);
   endsequence

   AST_FORCE_PWM_IGNORED: assert property (
      (wr_ctrl && pwdata_i[`TCW_BIT_FORCE] && wr_pwm && !tick)
      |=> $stable(s_q.oc))
      else $error("force strobe acted in a PWM mode");

   AST_FORCE_TOGGLES: assert property (force_toggle_s |=>
      s_q.oc != $past(s_q.oc))
      else $error("forced compare did not toggle the output");

   AST_FORCE_NO_SIDE: assert property (
      (force_cmp && !tick && !wr_stat) |=> $stable(s_q.cmf) && $stable(s_q.cnt))
      else $error("forced compare touched flag or counter");

   AST_STROBE_READS_ZERO: assert property (
      (access && !pwrite_i && paddr_i == `TCW_OFF_CTRL) |-> !prdata_o[7])
      else $error("force strobe read back as one");

   AST_STOPPED: assert property (
      (psc_sel == 3'h0 && !wr_cnt) |=> $stable(s_q.cnt))
      else $error("counter moved with no clock selected");

   AST_CTC_CLEAR: assert property (
      (tick && mode == tcw_pkg::TCW_CLEAR_ON_MATCH && match && !s_q.block
       && !wr_cnt) |=> s_q.cnt == `TCW_BOTTOM && s_q.cmf)
      else $error("clear-on-match did not clear and flag");

   AST_FAST_WRAP: assert property (
      (tick && mode == tcw_pkg::TCW_FAST_PWM && at_top && !wr_cnt && !wr_stat)
      |=> s_q.cnt == `TCW_BOTTOM && s_q.ovf)
      else $error("fast PWM did not wrap with overflow");

   AST_PC_HOLD_MAX: assert property (
      (tick && mode == tcw_pkg::TCW_PHASE_PWM && at_top && !s_q.down
       && !wr_cnt && !wr_ctrl) |=> s_q.down && s_q.cnt == 8'hFE)
      else $error("phase PWM did not turn at MAX");

   AST_BLOCKED_MATCH: assert property (
      (tick && s_q.block && !s_q.cmf && !wr_stat) |=> !s_q.cmf)
      else $error("match not suppressed after counter write");

   AST_TOP_HOLD: assert property (
      (tick && hold_top && at_top && !wr_ctrl) |=> s_q.oc != act[0])
      else $error("output not set at top with compare at MAX");

   AST_PIN_DRIVER: assert property (
      ##1 compare_out_oe_o == s_q.cfg[`TCW_BIT_DIR])
      else $error("pin driver does not follow direction bit");

endmodule

// >>> testbench/tcw_tb.sv
// self-checking bench of the timer/compare/waveform unit over APB
// assumes tcw_pkg is compiled first and tcw_consts.svh is on the include path
`include "tcw_consts.svh"

module tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clk_i        = 1'b0;
   logic        arst_n_i     = 1'b0;
   logic        psel_i       = 1'b0;
   logic        penable_i    = 1'b0;
   logic        pwrite_i     = 1'b0;
   logic [7:0]  paddr_i      = 8'h00;
   logic [31:0] pwdata_i     = 32'h0;
   logic        tosc_tick_i  = 1'b0;
   logic        port_out_i   = 1'b0;
   logic [31:0] prdata_o;
   logic        pready_o;
   logic        pslverr_o;
   logic        compare_out_pin_o;
   logic        compare_out_oe_o;
   logic        overflow_flag_o;
   logic        compare_match_flag_o;
   logic [31:0] rdata;
   logic        rerr;
   int          fail_count   = 0;
   int          checks_done  = 0;
   int          cyc          = 0;

   tcw_timer DUT (
      .clk_i                (clk_i),
      .arst_n_i             (arst_n_i),
      .psel_i               (psel_i),
      .penable_i            (penable_i),
      .pwrite_i             (pwrite_i),
      .paddr_i              (paddr_i),
      .pwdata_i             (pwdata_i),
      .prdata_o             (prdata_o),
      .pready_o             (pready_o),
      .pslverr_o            (pslverr_o),
      .tosc_tick_i          (tosc_tick_i),
      .port_out_i           (port_out_i),
      .compare_out_pin_o    (compare_out_pin_o),
      .compare_out_oe_o     (compare_out_oe_o),
      .overflow_flag_o      (overflow_flag_o),
      .compare_match_flag_o (compare_match_flag_o)
   );

   always #5 clk_i = ~clk_i;

   // ------------------------------------------------------------------
   // verdict, timeout and comparison
   // ------------------------------------------------------------------
   task automatic stop_test();
      if (fail_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // whole run needs well under this many cycles
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fail_count++;
         stop_test();
      end
   end

   task automatic chk(input string name, input logic [31:0] seen,
                      input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // expected value is seen only when within tol of mid
   function automatic logic [31:0] near(input logic [31:0] seen,
                                        input int mid, input int tol);
      if (seen + tol >= mid && seen <= mid + tol)
         return seen;
      return mid;
   endfunction

   function automatic logic [31:0] cb(input logic f, input logic [1:0] m,
                                      input logic [1:0] a,
                                      input logic [2:0] p);
      return {24'h0, f, m[0], a, m[1], p};
   endfunction

   // ------------------------------------------------------------------
   // APB master: request held until pready is sampled high
   // ------------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk_i);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do
         @(posedge clk_i);
      while (pready_o !== 1'b1);
      rdata = prdata_o;
      rerr  = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask

   task automatic run(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   localparam logic [1:0] NRM = tcw_pkg::TCW_NORMAL;
   localparam logic [1:0] PHS = tcw_pkg::TCW_PHASE_PWM;
   localparam logic [1:0] CLR = tcw_pkg::TCW_CLEAR_ON_MATCH;
   localparam logic [1:0] FST = tcw_pkg::TCW_FAST_PWM;

   int          divs[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
   logic [1:0]  fm[4]   = '{2'h0, 2'h2, 2'h0, 2'h2};
   logic [1:0]  fa[4]   = '{2'h3, 2'h2, 2'h1, 2'h1};
   logic        fp[4]   = '{1'b1, 1'b0, 1'b1, 1'b0};

   initial begin
      logic [31:0] v;
      logic        t;
      int          n;
      void'($urandom(32'h8D55));
      repeat (16) @(posedge clk_i);
      arst_n_i <= 1'b1;
      rd(`TCW_OFF_CTRL);
      chk("ctrl_reset", rdata, 32'h0);
      chk("oe_reset", {31'h0, compare_out_oe_o}, 32'h0);
      rd(8'h14);
      chk("unmapped_err", {31'h0, rerr}, 32'h1);
      // random control values; force kept low in PWM modes
      for (int i = 0; i < 12; i++) begin
         v = $urandom & 32'hFF;
         if (v[6]) v[7] = 1'b0;
         wr(`TCW_OFF_CTRL, v);
         rd(`TCW_OFF_CTRL);
         chk("ctrl_readback", rdata, v & 32'h7F);
      end
      wr(`TCW_OFF_CTRL, 32'h0);
      for (int i = 1; i < 8; i++) begin
         wr(`TCW_OFF_COUNT, 32'h0);
         wr(`TCW_OFF_CTRL, cb(1'b0, NRM, 2'h0, 3'(i)));
         run(4 * divs[i]);
         wr(`TCW_OFF_CTRL, 32'h0);
         rd(`TCW_OFF_COUNT);
         chk("prescale_ticks", rdata, near(rdata, 4 + 3 / divs[i], 2));
      end
      wr(`TCW_OFF_COUNT, 32'h3C);
      run(50);
      rd(`TCW_OFF_COUNT);
      chk("stopped_count", rdata, 32'h3C);
      // pass-through of port data while disconnected
      wr(`TCW_OFF_PINCFG, 32'h1);
      port_out_i <= 1'($urandom);
      run(2);
      chk("oe_dir", {31'h0, compare_out_oe_o}, 32'h1);
      chk("pin_port", {31'h0, compare_out_pin_o}, {31'h0, port_out_i});
      // forced compares while stopped, no match possible
      wr(`TCW_OFF_COMPARE, 32'h55);
      wr(`TCW_OFF_COUNT, 32'h20);
      wr(`TCW_OFF_STATUS, 32'h3);
      for (int i = 0; i < 4; i++) begin
         wr(`TCW_OFF_CTRL, cb(1'b1, fm[i], fa[i], 3'h0));
         run(1);
         chk("force_pin", {31'h0, compare_out_pin_o}, {31'h0, fp[i]});
      end
      rd(`TCW_OFF_COUNT);
      chk("force_count", rdata, 32'h20);
      rd(`TCW_OFF_STATUS);
      chk("force_flags", rdata, 32'h0);
      wr(`TCW_OFF_CTRL, cb(1'b1, FST, 2'h3, 3'h0));
      run(1);
      chk("force_pwm", {31'h0, compare_out_pin_o}, 32'h0);
      // overflow at MAX in normal mode
      wr(`TCW_OFF_CTRL, 32'h0);
      wr(`TCW_OFF_COUNT, 32'hF0);
      wr(`TCW_OFF_CTRL, cb(1'b0, NRM, 2'h0, 3'h1));
      run(30);
      wr(`TCW_OFF_CTRL, 32'h0);
      rd(`TCW_OFF_STATUS);
      chk("normal_ovf", rdata, 32'h1);
      chk("ovf_out", {31'h0, overflow_flag_o}, 32'h1);
      wr(`TCW_OFF_STATUS, 32'h3);
      rd(`TCW_OFF_STATUS);
      chk("flag_clear", rdata, 32'h0);
      // counter write masks the match on the first tick
      wr(`TCW_OFF_CTRL, cb(1'b0, NRM, 2'h1, 3'h0));
      wr(`TCW_OFF_COMPARE, 32'h5);
      wr(`TCW_OFF_COUNT, 32'h5);
      wr(`TCW_OFF_CTRL, cb(1'b0, NRM, 2'h1, 3'h1));
      run(2);
      wr(`TCW_OFF_CTRL, cb(1'b0, NRM, 2'h1, 3'h0));
      rd(`TCW_OFF_STATUS);
      chk("blocked_match", rdata, 32'h0);
      chk("blocked_pin", {31'h0, compare_out_pin_o}, 32'h0);
      // clear-on-match keeps the count at or below the compare value
      wr(`TCW_OFF_COUNT, 32'h0);
      wr(`TCW_OFF_CTRL, cb(1'b0, CLR, 2'h1, 3'h1));
      run(40);
      wr(`TCW_OFF_CTRL, cb(1'b0, CLR, 2'h1, 3'h0));
      rd(`TCW_OFF_COUNT);
      chk("ctc_top", rdata, near(rdata, 2, 3));
      rd(`TCW_OFF_STATUS);
      chk("ctc_flags", rdata, 32'h2);
      chk("cmf_out", {31'h0, compare_match_flag_o}, 32'h1);
      // fast PWM: new compare waits for MAX
      wr(`TCW_OFF_STATUS, 32'h3);
      wr(`TCW_OFF_CTRL, cb(1'b1, NRM, 2'h2, 3'h0));
      wr(`TCW_OFF_COMPARE, 32'h10);
      wr(`TCW_OFF_CTRL, cb(1'b0, FST, 2'h3, 3'h0));
      wr(`TCW_OFF_COMPARE, 32'h40);
      wr(`TCW_OFF_COUNT, 32'h8);
      wr(`TCW_OFF_CTRL, cb(1'b0, FST, 2'h3, 3'h1));
      run(16);
      wr(`TCW_OFF_CTRL, cb(1'b0, FST, 2'h3, 3'h0));
      chk("fast_old_cmp", {31'h0, compare_out_pin_o}, 32'h1);
      wr(`TCW_OFF_STATUS, 32'h3);
      wr(`TCW_OFF_COUNT, 32'hF0);
      wr(`TCW_OFF_CTRL, cb(1'b0, FST, 2'h3, 3'h1));
      run(30);
      wr(`TCW_OFF_CTRL, cb(1'b0, FST, 2'h3, 3'h0));
      chk("fast_top", {31'h0, compare_out_pin_o}, 32'h0);
      rd(`TCW_OFF_COUNT);
      chk("fast_wrap", rdata, near(rdata, 32'h11, 4));
      rd(`TCW_OFF_STATUS);
      chk("fast_ovf", rdata, 32'h1);
      wr(`TCW_OFF_COUNT, 32'h38);
      wr(`TCW_OFF_CTRL, cb(1'b0, FST, 2'h3, 3'h1));
      run(16);
      wr(`TCW_OFF_CTRL, cb(1'b0, FST, 2'h3, 3'h0));
      chk("fast_new_cmp", {31'h0, compare_out_pin_o}, 32'h1);
      // phase correct PWM: up match clears, down match sets
      wr(`TCW_OFF_STATUS, 32'h3);
      wr(`TCW_OFF_CTRL, cb(1'b0, NRM, 2'h2, 3'h0));
      wr(`TCW_OFF_COMPARE, 32'h80);
      wr(`TCW_OFF_COUNT, 32'h70);
      wr(`TCW_OFF_CTRL, cb(1'b0, PHS, 2'h2, 3'h1));
      run(40);
      wr(`TCW_OFF_CTRL, cb(1'b0, PHS, 2'h2, 3'h0));
      chk("phase_up", {31'h0, compare_out_pin_o}, 32'h0);
      wr(`TCW_OFF_CTRL, cb(1'b0, PHS, 2'h2, 3'h1));
      run(260);
      wr(`TCW_OFF_CTRL, cb(1'b0, PHS, 2'h2, 3'h0));
      chk("phase_down", {31'h0, compare_out_pin_o}, 32'h1);
      rd(`TCW_OFF_COUNT);
      chk("phase_count", rdata, near(rdata, 32'h5D, 8));
      rd(`TCW_OFF_STATUS);
      chk("phase_flags", rdata, 32'h2);
      // compare at MAX: match ignored, output still set at top
      wr(`TCW_OFF_CTRL, cb(1'b1, NRM, 2'h2, 3'h0));
      wr(`TCW_OFF_COMPARE, 32'hFF);
      wr(`TCW_OFF_COUNT, 32'hF8);
      wr(`TCW_OFF_CTRL, cb(1'b0, FST, 2'h2, 3'h1));
      run(12);
      wr(`TCW_OFF_CTRL, cb(1'b0, FST, 2'h2, 3'h0));
      chk("top_hold", {31'h0, compare_out_pin_o}, 32'h1);
      // oscillator ticks replace the clock in async mode
      wr(`TCW_OFF_CTRL, 32'h0);
      wr(`TCW_OFF_COUNT, 32'h0);
      wr(`TCW_OFF_PINCFG, 32'h3);
      wr(`TCW_OFF_CTRL, cb(1'b0, NRM, 2'h0, 3'h1));
      n = 0;
      t = 1'b0;
      repeat (40) begin
         @(posedge clk_i);
         t = 1'($urandom) & ~t;
         tosc_tick_i <= t;
         n += t;
      end
      @(posedge clk_i);
      tosc_tick_i <= 1'b0;
      run(2);
      wr(`TCW_OFF_CTRL, 32'h0);
      rd(`TCW_OFF_COUNT);
      chk("async_count", rdata, 32'(n));
      stop_test();
   end
endmodule
